// file: design/pwmie_pkg.sv
/*
  pwmie_pkg: register offsets, bit positions and reset values for the
  interrupt enable set/clear block of the pulse-width modulation unit.
  assumes a plain register port with byte addresses.
*/
package pwmie_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int PWMIE_AW = 12;
  localparam logic [11:0] PWMIE_OFS_SET = 12'h304;
  localparam logic [11:0] PWMIE_OFS_CLR = 12'h308;
  localparam logic [11:0] PWMIE_OFS_LOOPCNT = 12'h30c;
  localparam logic [31:0] PWMIE_RESET = 32'h00000000;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int PWMIE_B_STOP = 1;
  localparam int PWMIE_B_SEQSTART0 = 2;
  localparam int PWMIE_B_SEQSTART1 = 3;
  localparam int PWMIE_B_SEQEND0 = 4;
  localparam int PWMIE_B_SEQEND1 = 5;
  localparam int PWMIE_B_PERIOD = 6;
  localparam int PWMIE_B_LOOPS = 7;
  localparam logic [31:0] PWMIE_MASK = 32'h000000fe;
  localparam int PWMIE_CW = 16;
endpackage

// file: design/pwmie_top.sv
/*
  pwmie_top: shared interrupt enable state with write-one-to-set and
  write-one-to-clear views, loop counter for the loops-done event and
  gated interrupt request.
  assumes events are one-cycle pulses on CLK_I from the waveform engine.
*/
// The address-and-strobe port was chosen for this implementation.
// Contract
// - set-register one enables stopped interrupt
// - set bits enable sequence-started interrupts zero/one
// - set bits enable sequence-end interrupts zero/one
// - set bit enables period-end interrupt
// - set bit enables loops-done interrupt
// - clear bit disables stopped; reads show state
// - clear bits disable sequence-started interrupts
// - clear bits disable sequence-end interrupts
// - loops-done raised after loop count plays
`timescale 1ns/1ns
`default_nettype none
module pwmie_top
  import pwmie_pkg::*;
#(
  parameter int CW = PWMIE_CW
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [PWMIE_AW-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic STOPPED_I,
  input wire logic [1:0] SEQ_STARTED_I,
  input wire logic [1:0] SEQ_END_I,
  input wire logic PERIOD_END_I,
  output logic LOOPS_DONE_O,
  output logic IRQ_O
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] en;
    logic [31:0] rdata;
    logic [CW-1:0] loop_count_setting;
    logic [CW-1:0] loops;
    logic done;
  } pwmie_state_t;

  pwmie_state_t s_reg;
  pwmie_state_t s_next;
  logic [31:0] ev;
  logic wr_set;
  logic wr_clr;

  assign wr_set = WR_I && (ADDR_I == PWMIE_OFS_SET);
  assign wr_clr = WR_I && (ADDR_I == PWMIE_OFS_CLR);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    // ones set, zeros leave untouched
    if (wr_set) begin
      s_next.en = s_reg.en | (WDATA_I & PWMIE_MASK);
    end
    // ones clear, zeros leave untouched
    if (wr_clr) begin
      s_next.en = s_reg.en & ~(WDATA_I & PWMIE_MASK);
    end
    if (WR_I && (ADDR_I == PWMIE_OFS_LOOPCNT)) begin
      s_next.loop_count_setting = WDATA_I[CW-1:0];
      s_next.loops = '0;
    end
    // one loop is both sequences played, counted at sequence 1 end
    if (SEQ_END_I[1] && (s_reg.loop_count_setting != '0)) begin
      if (s_reg.loops == s_reg.loop_count_setting - 1'b1) begin
        s_next.done = 1'b1;
        s_next.loops = '0;
      end else begin
        s_next.loops = s_reg.loops + 1'b1;
      end
    end
    s_next.rdata = '0;
    if (RD_I) begin
      case (ADDR_I)
        // both views show one shared state
        PWMIE_OFS_SET: s_next.rdata = s_reg.en;
        PWMIE_OFS_CLR: s_next.rdata = s_reg.en;
        PWMIE_OFS_LOOPCNT: s_next.rdata = {{(32-CW){1'b0}}, s_reg.loop_count_setting};
        default: s_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s_reg <= '0; // all enables off
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb begin
    ev = '0;
    ev[PWMIE_B_STOP] = STOPPED_I;
    ev[PWMIE_B_SEQSTART0] = SEQ_STARTED_I[0];
    ev[PWMIE_B_SEQSTART1] = SEQ_STARTED_I[1];
    ev[PWMIE_B_SEQEND0] = SEQ_END_I[0];
    ev[PWMIE_B_SEQEND1] = SEQ_END_I[1];
    ev[PWMIE_B_PERIOD] = PERIOD_END_I;
    ev[PWMIE_B_LOOPS] = s_reg.done;
  end

  assign RDATA_O = s_reg.rdata;
  assign LOOPS_DONE_O = s_reg.done;
  // pulse per enabled event; no pending flags kept here
  assign IRQ_O = |(ev & s_reg.en);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_set_stop;
    @(posedge CLK_I) disable iff (RST_I)
    wr_set && WDATA_I[PWMIE_B_STOP] && !wr_clr |=> s_reg.en[PWMIE_B_STOP];
  endproperty
  a_set_stop: assert property (p_set_stop) else $error("stop enable not set");

  property p_set_seqs;
    @(posedge CLK_I) disable iff (RST_I)
    wr_set |=> (s_reg.en[PWMIE_B_SEQSTART1:PWMIE_B_SEQSTART0] &
      $past(WDATA_I[PWMIE_B_SEQSTART1:PWMIE_B_SEQSTART0])) ==
      $past(WDATA_I[PWMIE_B_SEQSTART1:PWMIE_B_SEQSTART0]);
  endproperty
  a_set_seqs: assert property (p_set_seqs) else $error("seq start enable not set");

  property p_set_seqe;
    @(posedge CLK_I) disable iff (RST_I)
    wr_set && WDATA_I[PWMIE_B_SEQEND1] |=> s_reg.en[PWMIE_B_SEQEND1];
  endproperty
  a_set_seqe: assert property (p_set_seqe) else $error("seq end enable not set");

  property p_set_seqe0;
    @(posedge CLK_I) disable iff (RST_I)
    wr_set && WDATA_I[PWMIE_B_SEQEND0] |=> s_reg.en[PWMIE_B_SEQEND0];
  endproperty
  a_set_seqe0: assert property (p_set_seqe0) else $error("seq end 0 enable not set");

  property p_set_period;
    @(posedge CLK_I) disable iff (RST_I)
    wr_set && WDATA_I[PWMIE_B_PERIOD] ##1 PERIOD_END_I |-> IRQ_O;
  endproperty
  a_set_period: assert property (p_set_period) else $error("period irq missing");

  property p_set_period_late;
    @(posedge CLK_I) disable iff (RST_I)
    wr_set && WDATA_I[PWMIE_B_PERIOD] ##1 !wr_clr ##1 PERIOD_END_I |-> IRQ_O;
  endproperty
  a_set_period_late: assert property (p_set_period_late) else $error("period irq lost");

  property p_set_loops;
    @(posedge CLK_I) disable iff (RST_I)
    wr_set && WDATA_I[PWMIE_B_LOOPS] |=> s_reg.en[PWMIE_B_LOOPS];
  endproperty
  a_set_loops: assert property (p_set_loops) else $error("loops enable not set");

  sequence s_clr_stop;
    wr_clr && WDATA_I[PWMIE_B_STOP];
  endsequence
  // either view reads the same shared state
  sequence s_read_en;
    RD_I && (ADDR_I == PWMIE_OFS_SET || ADDR_I == PWMIE_OFS_CLR);
  endsequence
  property p_clr_stop;
    @(posedge CLK_I) disable iff (RST_I)
    s_clr_stop ##1 s_read_en |=> !RDATA_O[PWMIE_B_STOP];
  endproperty
  a_clr_stop: assert property (p_clr_stop) else $error("stop still enabled");

  property p_clr_stop_late;
    @(posedge CLK_I) disable iff (RST_I)
    s_clr_stop ##1 !wr_set ##1 s_read_en |=> !RDATA_O[PWMIE_B_STOP];
  endproperty
  a_clr_stop_late: assert property (p_clr_stop_late) else $error("stop read back on");

  // read data must not linger past its one cycle
  property p_rdata_idle;
    @(posedge CLK_I) disable iff (RST_I)
    !RD_I |=> RDATA_O == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  property p_clr_seqs;
    @(posedge CLK_I) disable iff (RST_I)
    wr_clr && WDATA_I[PWMIE_B_SEQSTART0] |=> !s_reg.en[PWMIE_B_SEQSTART0];
  endproperty
  a_clr_seqs: assert property (p_clr_seqs) else $error("seq start not cleared");

  property p_clr_seqs1;
    @(posedge CLK_I) disable iff (RST_I)
    wr_clr && WDATA_I[PWMIE_B_SEQSTART1] |=> !s_reg.en[PWMIE_B_SEQSTART1];
  endproperty
  a_clr_seqs1: assert property (p_clr_seqs1) else $error("seq start 1 not cleared");

  property p_clr_seqe;
    @(posedge CLK_I) disable iff (RST_I)
    wr_clr && WDATA_I[PWMIE_B_SEQEND0] |=> !s_reg.en[PWMIE_B_SEQEND0] &&
      (ev != (32'h1 << PWMIE_B_SEQEND0) || !IRQ_O);
  endproperty
  a_clr_seqe: assert property (p_clr_seqe) else $error("seq end not cleared");

  property p_clr_seqe1;
    @(posedge CLK_I) disable iff (RST_I)
    wr_clr && WDATA_I[PWMIE_B_SEQEND1] |=> !s_reg.en[PWMIE_B_SEQEND1];
  endproperty
  a_clr_seqe1: assert property (p_clr_seqe1) else $error("seq end 1 not cleared");

  property p_loops;
    @(posedge CLK_I) disable iff (RST_I)
    LOOPS_DONE_O |-> $past(SEQ_END_I[1]) && $past(s_reg.loop_count_setting) != '0;
  endproperty
  a_loops: assert property (p_loops) else $error("loops done without cause");

  property p_zero_hold;
    @(posedge CLK_I) disable iff (RST_I)
    !wr_set && !wr_clr |=> $stable(s_reg.en);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("enables changed");
endmodule
`default_nettype wire

// file: tb/pwmie_testbench.sv
/*
  testbench: drives the enable set/clear registers, the event pulses and the
  loop count of pwmie_top and compares reads and outputs with expectations.
  assumes the design package and pwmie_top are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench
  import pwmie_pkg::*;
;
  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  logic clk, rst, wr, rd, stopped, per, done, irq;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, expv;
  logic [1:0] sst, send;
  int errors, checks_done;

  pwmie_top DUT (
    .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .STOPPED_I(stopped), .SEQ_STARTED_I(sst), .SEQ_END_I(send),
    .PERIOD_END_I(per), .LOOPS_DONE_O(done), .IRQ_O(irq)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask

  // e uses the enable bit positions; irq is a pulse, checked in its cycle
  task automatic ev(input logic [7:0] e, input logic exp_irq, input logic exp_done);
    @(posedge clk);
    stopped <= e[1];
    sst <= e[3:2];
    send <= e[5:4];
    per <= e[6];
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, exp_irq});
    @(posedge clk);
    {stopped, sst, send, per} <= 6'h00;
    @(negedge clk);
    chk({30'h0, done, irq}, {30'h0, exp_done, exp_done});
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst, wr, rd, stopped, sst, send, per} = 9'h100;
    addr = 12'h000;
    wdata = 32'h0;
    errors = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_chk(PWMIE_OFS_SET, PWMIE_RESET);
    rd_chk(PWMIE_OFS_CLR, PWMIE_RESET);
    expv = 32'h0;
    for (int i = 1; i < 8; i++) begin
      wr_reg(PWMIE_OFS_SET, 32'h1 << i);
      expv |= 32'h1 << i;
      rd_chk(PWMIE_OFS_SET, expv);
    end
    wr_reg(PWMIE_OFS_SET, 32'h0);
    rd_chk(PWMIE_OFS_CLR, 32'hfe);
    for (int i = 1; i < 7; i++)
      ev(8'h1 << i, 1'b1, 1'b0);
    for (int i = 1; i < 8; i++) begin
      wr_reg(PWMIE_OFS_CLR, 32'h1 << i);
      expv &= ~(32'h1 << i);
      rd_chk(PWMIE_OFS_CLR, expv);
      ev((8'h1 << i) & 8'h7f, 1'b0, 1'b0);
    end
    // unmapped address must not touch the enables
    wr_reg(12'h300, 32'hff);
    rd_chk(12'h300, 32'h0);
    rd_chk(PWMIE_OFS_SET, 32'h0);
    wr_reg(PWMIE_OFS_SET, 32'h40);
    ev(8'h40, 1'b1, 1'b0);
    wr_reg(PWMIE_OFS_SET, 32'h80);
    wr_reg(PWMIE_OFS_LOOPCNT, 32'h2);
    rd_chk(PWMIE_OFS_LOOPCNT, 32'h2);
    ev(8'h20, 1'b0, 1'b0);
    ev(8'h20, 1'b0, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
